/* File: logic/cfm_fault_manager.sv */
// converter fault manager top: comparator capture, status registers and responses
`timescale 1ns/10ps
`default_nettype none
`include "cfm_defs.svh"
module cfm_fault_manager #(
    parameter int NPH = `CFM_PH_COUNT,
    parameter int HICCUP_CYCLES = `CFM_HICCUP_MS * `CFM_CLK_KHZ
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic INPUT_SUPPLY_OV,
    input wire logic DRIVER_SUPPLY_RAIL_OV,
    input wire logic DRIVER_SUPPLY_RAIL_UV,
    input wire logic CORE_SUPPLY_RAIL_OV,
    input wire logic CORE_SUPPLY_RAIL_UV,
    input wire logic FLYBACK_OC,
    input wire logic AVERAGE_OVERCURRENT_FAULT,
    input wire logic [NPH-1:0] PEAK_CURRENT_LIMIT,
    input wire logic [NPH-1:0] PEAK_OVERCURRENT_FAULT,
    input wire logic [NPH-1:0] NEGATIVE_CURRENT_LIMIT,
    input wire logic EN,
    input wire logic EN_SWITCHING,
    input wire logic MODE_LATCH_OFF,
    input wire logic MODE_FORCED_PWM,
    input wire logic BOOST_MODE,
    input wire logic [NPH-1:0] CYCLE_START,
    input wire logic [NPH-1:0] MAIN_REQ,
    input wire logic [NPH-1:0] SYNC_REQ,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic [NPH-1:0] HS_GATE,
    output logic [NPH-1:0] LS_GATE,
    output logic ALERT_FLAG_N,
    output logic MAIN_RUN,
    output logic FLYBACK_RUN,
    output logic INIT_REQ,
    output logic SOFTSTART_REQ,
    output logic FORCED_PWM
);
    localparam int NPIN = 10 + 3 * NPH;
    // enable pins idle high; their sync flops reset high so no false toggle follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = NPIN'(2'h3) << (3 * NPH + 1);

    // -----------------------------------------------------------
    // response decode: {act, latch} from a two-bit override field
    // -----------------------------------------------------------
    // field bit 0 selects latch-off, bit 1 turns the shutdown into flag-only
    function automatic logic [1:0] resp(input logic [1:0] fld, input logic ovr,
                                        input logic pin_latch);
        if (ovr)
            resp = {~fld[1], fld[0]};
        else
            resp = {1'b1, pin_latch};
    endfunction

    cfm_seq_if sq();

    logic [NPIN-1:0] pin_s1_q, pin_s2_q;
    logic [1:0] settle_q;
    logic in_ov, drv_ov, drv_uv, core_ov, core_uv, fly_oc, avg_oc, en_s, enp_s, boost_s;
    logic [NPH-1:0] plim, pflt, nlim;
    logic en_q, enp_q, en_seen_low_q, enp_seen_low_q, en_seen_low_d, enp_seen_low_d;
    cfm_pkg::cfm_byte_t ovr_q, ovr_d, fresp_q, fresp_d, cresp_q, cresp_d, presp_q, presp_d;
    cfm_pkg::cfm_byte_t fstat_q, fstat_d, ostat_q, ostat_d, limph_q, limph_d, fltph_q, fltph_d;
    cfm_pkg::cfm_byte_t fset, oset, lset, pset, rdata_d, rdata_q;
    logic alert_n_d, alert_n_q;
    logic [1:0] r_cov, r_cuv, r_dov, r_duv, r_foc, r_aoc, r_pk;
    logic ovr_en, wr_ovr, wr_fresp, wr_cresp, wr_presp;

    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    // comparators and pins are asynchronous; two flops before any logic
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
            settle_q <= 2'h3;
        end
        else
        begin
            // init is held until the sync flops carry real pin levels
            settle_q <= {settle_q[0], 1'b0};
            pin_s1_q <= {INPUT_SUPPLY_OV, DRIVER_SUPPLY_RAIL_OV, DRIVER_SUPPLY_RAIL_UV,
                         CORE_SUPPLY_RAIL_OV, CORE_SUPPLY_RAIL_UV, FLYBACK_OC,
                         AVERAGE_OVERCURRENT_FAULT, EN, EN_SWITCHING, BOOST_MODE,
                         PEAK_CURRENT_LIMIT, PEAK_OVERCURRENT_FAULT, NEGATIVE_CURRENT_LIMIT};
            pin_s2_q <= pin_s1_q;
        end
    end

    // mode straps sync separately; sequencer only looks at them during init
    logic [1:0] mode_s1_q, mode_s2_q;
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
        end
        else
        begin
            mode_s1_q <= {MODE_LATCH_OFF, MODE_FORCED_PWM};
            mode_s2_q <= mode_s1_q;
        end
    end

    // unpack synchronised pins
    assign {in_ov, drv_ov, drv_uv, core_ov, core_uv, fly_oc, avg_oc, en_s, enp_s, boost_s,
            plim, pflt, nlim} = pin_s2_q;

    // -----------------------------------------------------------
    // enable toggle detection
    // -----------------------------------------------------------
    // a toggle needs a low seen first, then a high; a glitch-free high alone is ignored
    always_comb
    begin
        en_seen_low_d = (en_seen_low_q | ~en_s) & ~(en_s & ~en_q & en_seen_low_q);
        enp_seen_low_d = (enp_seen_low_q | ~enp_s) & ~(enp_s & ~enp_q & enp_seen_low_q);
        sq.en_rise = en_s & ~en_q & en_seen_low_q;
        sq.enpwm_rise = enp_s & ~enp_q & enp_seen_low_q;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            en_q <= 1'b1;
            enp_q <= 1'b1;
            en_seen_low_q <= 1'b0;
            enp_seen_low_q <= 1'b0;
        end
        else
        begin
            en_q <= en_s;
            enp_q <= enp_s;
            en_seen_low_q <= en_seen_low_d;
            enp_seen_low_q <= enp_seen_low_d;
        end
    end

    // -----------------------------------------------------------
    // fault responses
    // -----------------------------------------------------------
    always_comb
    begin
        ovr_en = ovr_q[`CFM_BIT_OVR_EN];
        r_cov = resp(fresp_q[`CFM_FLD_CORE_OV], ovr_en, sq.mode_latch);
        r_cuv = resp(fresp_q[`CFM_FLD_CORE_UV], ovr_en, sq.mode_latch);
        r_dov = resp(fresp_q[`CFM_FLD_DRV_OV], ovr_en, sq.mode_latch);
        r_duv = resp(fresp_q[`CFM_FLD_DRV_UV], ovr_en, sq.mode_latch);
        r_foc = resp(cresp_q[`CFM_FLD_FLY_OC], ovr_en, sq.mode_latch);
        r_aoc = resp(cresp_q[`CFM_FLD_AVG_OC], ovr_en, sq.mode_latch);
        r_pk = resp(presp_q[`CFM_FLD_PEAK], ovr_en, sq.mode_latch);
        // rail faults only count while the flyback is supposed to be up
        fset = '0;
        fset[`CFM_BIT_CORE_OV] = core_ov & sq.fly_run;
        fset[`CFM_BIT_CORE_UV] = core_uv & sq.fly_run;
        fset[`CFM_BIT_DRV_OV] = drv_ov & sq.fly_run;
        fset[`CFM_BIT_DRV_UV] = drv_uv & sq.fly_run;
        fset[`CFM_BIT_FLY_OC] = fly_oc & sq.fly_run;
        // current faults only count while the main stage switches
        oset = '0;
        oset[`CFM_BIT_PEAK_LIM] = |plim & sq.main_run;
        oset[`CFM_BIT_PEAK_FLT] = |pflt & sq.main_run;
        oset[`CFM_BIT_NEG_LIM] = |nlim & sq.main_run;
        oset[`CFM_BIT_AVG_OC] = avg_oc & sq.main_run;
        lset = 8'(plim | nlim) & {8{sq.main_run}};
        pset = 8'(pflt) & {8{sq.main_run}};
        sq.full_fault = (fset[`CFM_BIT_CORE_OV] & r_cov[1]) | (fset[`CFM_BIT_CORE_UV] & r_cuv[1])
            | (fset[`CFM_BIT_DRV_OV] & r_dov[1]) | (fset[`CFM_BIT_DRV_UV] & r_duv[1])
            | (fset[`CFM_BIT_FLY_OC] & r_foc[1]);
        // any latching contributor makes the whole shutdown latch
        sq.full_latch = (fset[`CFM_BIT_CORE_OV] & r_cov[1] & r_cov[0])
            | (fset[`CFM_BIT_CORE_UV] & r_cuv[1] & r_cuv[0])
            | (fset[`CFM_BIT_DRV_OV] & r_dov[1] & r_dov[0])
            | (fset[`CFM_BIT_DRV_UV] & r_duv[1] & r_duv[0])
            | (fset[`CFM_BIT_FLY_OC] & r_foc[1] & r_foc[0]);
        sq.part_fault = (oset[`CFM_BIT_PEAK_FLT] & r_pk[1])
            | (oset[`CFM_BIT_AVG_OC] & r_aoc[1]);
        sq.part_latch = (oset[`CFM_BIT_PEAK_FLT] & r_pk[1] & r_pk[0])
            | (oset[`CFM_BIT_AVG_OC] & r_aoc[1] & r_aoc[0]);
        sq.in_ov = in_ov | (|settle_q);
        sq.mode_latch_pin = mode_s2_q[1];
        sq.mode_fpwm_pin = mode_s2_q[0];
    end

    // -----------------------------------------------------------
    // register file
    // -----------------------------------------------------------
    // status writes are write-one-to-clear; a set in the same cycle wins
    always_comb
    begin
        wr_ovr = REG_WR && REG_ADDR == `CFM_OFS_OVR_EN;
        wr_fresp = REG_WR && REG_ADDR == `CFM_OFS_FLY_RESP;
        wr_cresp = REG_WR && REG_ADDR == `CFM_OFS_CUR_RESP;
        wr_presp = REG_WR && REG_ADDR == `CFM_OFS_PEAK_RESP;
        ovr_d = wr_ovr ? REG_WDATA : ovr_q;
        fresp_d = wr_fresp ? REG_WDATA : fresp_q;
        cresp_d = wr_cresp ? REG_WDATA : cresp_q;
        presp_d = wr_presp ? REG_WDATA : presp_q;
        fstat_d = (fstat_q & ~((REG_WR && REG_ADDR == `CFM_OFS_FLY_STAT) ? REG_WDATA : 8'h00))
            | fset;
        ostat_d = (ostat_q & ~((REG_WR && REG_ADDR == `CFM_OFS_OC_STAT) ? REG_WDATA : 8'h00))
            | oset;
        limph_d = (limph_q & ~((REG_WR && REG_ADDR == `CFM_OFS_LIM_PH) ? REG_WDATA : 8'h00))
            | lset;
        fltph_d = (fltph_q & ~((REG_WR && REG_ADDR == `CFM_OFS_FLT_PH) ? REG_WDATA : 8'h00))
            | pset;
        alert_n_d = ~(|fstat_d | |ostat_d);
        rdata_d = rdata_q;
        if (REG_RD)
        begin
            case (REG_ADDR)
                `CFM_OFS_OVR_EN: rdata_d = ovr_q;
                `CFM_OFS_FLY_RESP: rdata_d = fresp_q;
                `CFM_OFS_CUR_RESP: rdata_d = cresp_q;
                `CFM_OFS_PEAK_RESP: rdata_d = presp_q;
                `CFM_OFS_FLY_STAT: rdata_d = fstat_q;
                `CFM_OFS_OC_STAT: rdata_d = ostat_q;
                `CFM_OFS_LIM_PH: rdata_d = limph_q;
                `CFM_OFS_FLT_PH: rdata_d = fltph_q;
                default: rdata_d = 8'h00; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ovr_q <= `CFM_REG_RST;
            fresp_q <= `CFM_REG_RST;
            cresp_q <= `CFM_REG_RST;
            presp_q <= `CFM_REG_RST;
            fstat_q <= `CFM_REG_RST;
            ostat_q <= `CFM_REG_RST;
            limph_q <= `CFM_REG_RST;
            fltph_q <= `CFM_REG_RST;
            rdata_q <= 8'h00;
            alert_n_q <= 1'b1;
        end
        else
        begin
            ovr_q <= ovr_d;
            fresp_q <= fresp_d;
            cresp_q <= cresp_d;
            presp_q <= presp_d;
            fstat_q <= fstat_d;
            ostat_q <= ostat_d;
            limph_q <= limph_d;
            fltph_q <= fltph_d;
            rdata_q <= rdata_d;
            alert_n_q <= alert_n_d;
        end
    end

    // -----------------------------------------------------------
    // submodules and outputs
    // -----------------------------------------------------------
    cfm_restart_seq #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_seq (
        .clk(CLK_SYS),
        .rst(RST),
        .sq(sq.seq)
    );

    // limiter gates are registered inside, so they drive the pins directly
    cfm_phase_limiter #(.NPH(NPH)) u_lim (
        .clk(CLK_SYS),
        .rst(RST),
        .boost(boost_s),
        .main_en(sq.main_run),
        .cycle_start(CYCLE_START),
        .main_req(MAIN_REQ),
        .sync_req(SYNC_REQ),
        .peak_lim(plim),
        .neg_lim(nlim),
        .hs_q(HS_GATE),
        .ls_q(LS_GATE)
    );

    assign REG_RDATA = rdata_q;
    assign ALERT_FLAG_N = alert_n_q;
    assign MAIN_RUN = sq.main_run;
    assign FLYBACK_RUN = sq.fly_run;
    assign INIT_REQ = sq.init_pulse;
    assign SOFTSTART_REQ = sq.ss_pulse;
    assign FORCED_PWM = sq.mode_fpwm;
endmodule
`default_nettype wire

/* File: include/cfm_defs.svh */
// register offsets, field positions, reset values and timing figures of the fault manager
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

// register offsets
`define CFM_OFS_OVR_EN 8'hB0
`define CFM_OFS_FLY_RESP 8'hB3
`define CFM_OFS_CUR_RESP 8'hB4
`define CFM_OFS_PEAK_RESP 8'hB6
`define CFM_OFS_FLY_STAT 8'hD3
`define CFM_OFS_OC_STAT 8'hD5
`define CFM_OFS_LIM_PH 8'hD9
`define CFM_OFS_FLT_PH 8'hDA

// field positions
`define CFM_BIT_OVR_EN 7
`define CFM_BIT_CORE_OV 0
`define CFM_BIT_CORE_UV 1
`define CFM_BIT_DRV_OV 2
`define CFM_BIT_DRV_UV 3
`define CFM_BIT_FLY_OC 4
`define CFM_BIT_PEAK_LIM 0
`define CFM_BIT_PEAK_FLT 1
`define CFM_BIT_NEG_LIM 2
`define CFM_BIT_AVG_OC 5
`define CFM_FLD_CORE_OV 1:0
`define CFM_FLD_CORE_UV 3:2
`define CFM_FLD_DRV_OV 5:4
`define CFM_FLD_DRV_UV 7:6
`define CFM_FLD_FLY_OC 1:0
`define CFM_FLD_AVG_OC 5:4
`define CFM_FLD_PEAK 1:0

// reset values and phase count
`define CFM_REG_RST 8'h00
`define CFM_PH_COUNT 6

// timing
`define CFM_HICCUP_MS 500
`define CFM_CLK_KHZ 25000

`endif

/* File: include/cfm_pkg.sv */
// types shared by the fault manager modules
package cfm_pkg;
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_RUN = 3'h1,
        ST_HIC_FULL = 3'h2,
        ST_LAT_FULL = 3'h3,
        ST_HIC_MAIN = 3'h4,
        ST_LAT_MAIN = 3'h5
    } cfm_state_e;
    typedef logic [7:0] cfm_byte_t;
endpackage

/* File: include/cfm_seq_if.sv */
// carrier between the fault decoder and the restart sequencer
`timescale 1ns/10ps
`default_nettype none
interface cfm_seq_if;
    logic full_fault;
    logic full_latch;
    logic part_fault;
    logic part_latch;
    logic in_ov;
    logic en_rise;
    logic enpwm_rise;
    logic mode_latch_pin;
    logic mode_fpwm_pin;
    logic main_run;
    logic fly_run;
    logic init_pulse;
    logic ss_pulse;
    logic mode_latch;
    logic mode_fpwm;
    modport mgr (output full_fault, full_latch, part_fault, part_latch, in_ov, en_rise,
                 enpwm_rise, mode_latch_pin, mode_fpwm_pin,
                 input main_run, fly_run, init_pulse, ss_pulse, mode_latch, mode_fpwm);
    modport seq (input full_fault, full_latch, part_fault, part_latch, in_ov, en_rise,
                 enpwm_rise, mode_latch_pin, mode_fpwm_pin,
                 output main_run, fly_run, init_pulse, ss_pulse, mode_latch, mode_fpwm);
endinterface
`default_nettype wire

/* File: logic/cfm_phase_limiter.sv */
// cycle-by-cycle peak and negative current limiting of the phase switches
`timescale 1ns/10ps
`default_nettype none
module cfm_phase_limiter #(
    parameter int NPH = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic boost,
    input wire logic main_en,
    input wire logic [NPH-1:0] cycle_start,
    input wire logic [NPH-1:0] main_req,
    input wire logic [NPH-1:0] sync_req,
    input wire logic [NPH-1:0] peak_lim,
    input wire logic [NPH-1:0] neg_lim,
    output logic [NPH-1:0] hs_q,
    output logic [NPH-1:0] ls_q
);
    logic [NPH-1:0] blk_main_q, blk_main_d, blk_sync_q, blk_sync_d;
    logic [NPH-1:0] hs_d, ls_d, main_on, sync_on;

    // a trip blocks the switch until the phase's next cycle; a trip in the start cycle wins
    always_comb
    begin
        blk_main_d = (blk_main_q & ~cycle_start) | peak_lim;
        blk_sync_d = (blk_sync_q & ~cycle_start) | neg_lim;
        main_on = main_req & ~blk_main_d & {NPH{main_en}};
        // main has priority so the two switches of a leg are never on together
        sync_on = sync_req & ~blk_sync_d & ~main_on & {NPH{main_en}};
        hs_d = boost ? sync_on : main_on;
        ls_d = boost ? main_on : sync_on;
    end

    // registered gates
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            blk_main_q <= '0;
            blk_sync_q <= '0;
            hs_q <= '0;
            ls_q <= '0;
        end
        else
        begin
            blk_main_q <= blk_main_d;
            blk_sync_q <= blk_sync_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
        end
    end
endmodule
`default_nettype wire

/* File: logic/cfm_restart_seq.sv */
// restart sequencer: initialization, run, hiccup and latch-off states
`timescale 1ns/10ps
`default_nettype none
module cfm_restart_seq #(
    parameter int HICCUP_CYCLES = 12500000
) (
    input wire logic clk,
    input wire logic rst,
    cfm_seq_if.seq sq
);
    cfm_pkg::cfm_state_e st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic main_d, fly_d, init_d, ss_d, mlat_d, mfpwm_d;

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        mlat_d = sq.mode_latch;
        mfpwm_d = sq.mode_fpwm;
        init_d = 1'b0;
        ss_d = 1'b0;
        case (st_q)
            cfm_pkg::ST_INIT:
            begin
                // mode straps are caught here only, then held
                mlat_d = sq.mode_latch_pin;
                mfpwm_d = sq.mode_fpwm_pin;
                if (!sq.in_ov)
                begin
                    st_d = cfm_pkg::ST_RUN;
                    ss_d = 1'b1;
                end
            end
            cfm_pkg::ST_RUN, cfm_pkg::ST_HIC_MAIN, cfm_pkg::ST_LAT_MAIN:
            begin
                if (st_q != cfm_pkg::ST_RUN && cnt_q != 32'h0)
                    cnt_d = cnt_q - 32'h1;
                if (sq.full_fault)
                begin
                    st_d = sq.full_latch ? cfm_pkg::ST_LAT_FULL : cfm_pkg::ST_HIC_FULL;
                    cnt_d = 32'(HICCUP_CYCLES - 1);
                end
                else if (st_q == cfm_pkg::ST_RUN && sq.part_fault)
                begin
                    st_d = sq.part_latch ? cfm_pkg::ST_LAT_MAIN : cfm_pkg::ST_HIC_MAIN;
                    cnt_d = 32'(HICCUP_CYCLES - 1);
                end
                else if (st_q != cfm_pkg::ST_RUN && sq.en_rise)
                    st_d = cfm_pkg::ST_INIT;
                else if (st_q == cfm_pkg::ST_LAT_MAIN && sq.enpwm_rise)
                begin
                    st_d = cfm_pkg::ST_RUN;
                    ss_d = 1'b1;
                end
                else if (st_q == cfm_pkg::ST_HIC_MAIN && cnt_q == 32'h0)
                begin
                    st_d = cfm_pkg::ST_RUN;
                    ss_d = 1'b1;
                end
            end
            cfm_pkg::ST_HIC_FULL:
            begin
                if (cnt_q != 32'h0)
                    cnt_d = cnt_q - 32'h1;
                else
                    st_d = cfm_pkg::ST_INIT;
            end
            cfm_pkg::ST_LAT_FULL:
            begin
                if (sq.en_rise)
                    st_d = cfm_pkg::ST_INIT;
            end
            default: st_d = cfm_pkg::ST_INIT;
        endcase
        // input supply above limit holds everything off from any state
        if (sq.in_ov)
        begin
            st_d = cfm_pkg::ST_INIT;
            ss_d = 1'b0;
        end
        if (st_d == cfm_pkg::ST_INIT && st_q != cfm_pkg::ST_INIT)
            init_d = 1'b1;
        main_d = (st_d == cfm_pkg::ST_RUN);
        fly_d = (st_d != cfm_pkg::ST_INIT) && (st_d != cfm_pkg::ST_HIC_FULL)
            && (st_d != cfm_pkg::ST_LAT_FULL);
    end

    // state registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= cfm_pkg::ST_INIT;
            cnt_q <= 32'h0;
            sq.main_run <= 1'b0;
            sq.fly_run <= 1'b0;
            sq.init_pulse <= 1'b0;
            sq.ss_pulse <= 1'b0;
            sq.mode_latch <= 1'b0;
            sq.mode_fpwm <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sq.main_run <= main_d;
            sq.fly_run <= fly_d;
            sq.init_pulse <= init_d;
            sq.ss_pulse <= ss_d;
            sq.mode_latch <= mlat_d;
            sq.mode_fpwm <= mfpwm_d;
        end
    end
endmodule
`default_nettype wire

/* File: verif/cfm_fm_properties.sv */
// concurrent checks on the fault manager top ports
`timescale 1ns/10ps
`default_nettype none
module cfm_fm_properties #(parameter int NPH = 6) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic INPUT_SUPPLY_OV,
    input wire logic BOOST_MODE,
    input wire logic REG_WR,
    input wire logic [NPH-1:0] PEAK_CURRENT_LIMIT,
    input wire logic [NPH-1:0] NEGATIVE_CURRENT_LIMIT,
    input wire logic [NPH-1:0] HS_GATE,
    input wire logic [NPH-1:0] LS_GATE,
    input wire logic ALERT_FLAG_N,
    input wire logic MAIN_RUN,
    input wire logic FLYBACK_RUN,
    input wire logic SOFTSTART_REQ,
    input wire logic FORCED_PWM
);
    // one clock domain; windows allow for the two-flop input sync
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    chk_inov_hold: assert property (INPUT_SUPPLY_OV [*7] |-> !MAIN_RUN && !FLYBACK_RUN)
        else $error("run while input over limit");
    chk_stop_gates: assert property (!MAIN_RUN [*3] |-> HS_GATE == '0 && LS_GATE == '0)
        else $error("gate on while main stopped");
    chk_peak_cut: assert property ((PEAK_CURRENT_LIMIT[0] && !BOOST_MODE) [*5] |-> !HS_GATE[0])
        else $error("main switch on after peak trip");
    chk_neg_cut: assert property ((NEGATIVE_CURRENT_LIMIT[0] && !BOOST_MODE) [*5] |-> !LS_GATE[0])
        else $error("sync switch on after negative trip");
    chk_main_needs_fly: assert property (MAIN_RUN |-> FLYBACK_RUN)
        else $error("main runs without flyback");
    chk_alert_sticky: assert property (!ALERT_FLAG_N && !REG_WR |=> !ALERT_FLAG_N)
        else $error("alert released without host clear");
    chk_mode_held: assert property (FLYBACK_RUN [*3] |-> $stable(FORCED_PWM))
        else $error("mode changed outside init");
    chk_start_runs: assert property (SOFTSTART_REQ |-> ##[0:3] MAIN_RUN)
        else $error("soft-start without main run");
endmodule
`default_nettype wire

/* File: verif/cfm_host_pins.sv */
// host model of the enable pins
`timescale 1ns/10ps
`default_nettype none
module cfm_host_pins (
    input wire logic clk,
    input wire logic go_en,
    input wire logic go_sw,
    output logic en,
    output logic en_sw
);
    // pins idle high; a request holds one low so its rise is a whole toggle
    initial
    begin
        en = 1'b1;
        en_sw = 1'b1;
    end
    always @(posedge clk)
    begin
        en <= !go_en;
        en_sw <= !go_sw;
    end
endmodule
`default_nettype wire

/* File: verif/cfm_fault_manager_tb.sv */
// self-checking bench for the fault manager
`timescale 1ns/10ps
`default_nettype none
module cfm_fault_manager_tb;
    localparam int HC = 20;
    logic clk = 0, rst = 1, in_ov = 0, fly_oc = 0, avg_oc = 0, m_lat = 0, wr = 0, rd = 0, bst = 0;
    logic drv_ov = 0, drv_uv = 0, core_ov = 0, core_uv = 0, go_en = 0, go_sw = 0;
    logic en, en_sw, alert_n, main_run, fly_run, init_req, ss_req, fpwm;
    logic [5:0] peak = 0, pflt = 0, neg = 0, cst, mreq, sreq, hs, ls;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [2:0] ph = 0;
    int n_fail = 0, checks_done = 0, n;
    always #20 clk = !clk;
    // phase timing: requests swap every four clocks, cycle start every eight
    always @(posedge clk) ph <= #1 ph + 3'h1;
    assign cst = {6{ph == 3'h0}};
    assign mreq = {6{ph[2]}};
    assign sreq = {6{!ph[2]}};
    cfm_host_pins host (.clk(clk), .go_en(go_en), .go_sw(go_sw), .en(en), .en_sw(en_sw));
    cfm_fault_manager #(.HICCUP_CYCLES(HC)) DUT (.CLK_SYS(clk), .RST(rst),
        .INPUT_SUPPLY_OV(in_ov), .DRIVER_SUPPLY_RAIL_OV(drv_ov), .DRIVER_SUPPLY_RAIL_UV(drv_uv),
        .CORE_SUPPLY_RAIL_OV(core_ov), .CORE_SUPPLY_RAIL_UV(core_uv), .FLYBACK_OC(fly_oc),
        .AVERAGE_OVERCURRENT_FAULT(avg_oc), .PEAK_CURRENT_LIMIT(peak),
        .PEAK_OVERCURRENT_FAULT(pflt), .NEGATIVE_CURRENT_LIMIT(neg), .EN(en),
        .EN_SWITCHING(en_sw), .MODE_LATCH_OFF(m_lat), .MODE_FORCED_PWM(m_lat),
        .BOOST_MODE(bst), .CYCLE_START(cst), .MAIN_REQ(mreq), .SYNC_REQ(sreq),
        .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
        .HS_GATE(hs), .LS_GATE(ls), .ALERT_FLAG_N(alert_n), .MAIN_RUN(main_run),
        .FLYBACK_RUN(fly_run), .INIT_REQ(init_req), .SOFTSTART_REQ(ss_req), .FORCED_PWM(fpwm));
    // --------------------------------------------------------------
    // bus cycles, compare and bounded waits
    // --------------------------------------------------------------
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task stop_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // the gap cycle keeps a strobe from being lowered and raised in one step
    task wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        cyc(1);
        wr = 0;
        cyc(1);
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1;
        cyc(1);
        rd = 0;
        chk(nm, rdata, e);
        cyc(1);
    endtask
    task clr();
        wreg(8'hD3, 8'hFF);
        wreg(8'hD5, 8'hFF);
        wreg(8'hD9, 8'hFF);
        wreg(8'hDA, 8'hFF);
    endtask
    // k: 0 init pulse, 1 soft-start pulse, 2 main run
    task wt(input int k);
        n = 0;
        while (((k == 0) ? init_req : (k == 1) ? ss_req : main_run) !== 1'b1)
        begin
            cyc(1);
            n++;
            if (n > 4 * HC)
            begin
                n_fail++;
                $display("ERROR wait%0d expected 1 seen 0", k);
                stop_test();
            end
        end
    endtask
    task t_regs();
        rchk("ovr_en", 8'hB0, 8'h00);
        wreg(8'hB6, 8'h03);
        rchk("peak_resp", 8'hB6, 8'h03);
        wreg(8'hB6, 8'h00);
        rchk("unmapped", 8'hB5, 8'h00);
        $display("t_regs done");
    endtask
    task t_limits();
        peak = 6'h21;
        neg = 6'h01;
        cyc(7);
        chk("buck_gates", {5'h0, hs[5], hs[0], ls[0]}, 8'h00);
        bst = 1;
        cyc(4);
        chk("boost_gates", {5'h0, ls[5], ls[0], hs[0]}, 8'h00);
        bst = 0;
        peak = 0;
        neg = 0;
        cyc(2);
        rchk("oc_stat", 8'hD5, 8'h05);
        rchk("lim_ph", 8'hD9, 8'h21);
        chk("alert_run", {6'h0, alert_n, main_run}, 8'h01);
        clr();
        chk("alert_clr", {7'h0, alert_n}, 8'h01);
        $display("t_limits done");
    endtask
    // every full-shutdown fault in default hiccup, one at a time
    task t_rails();
        for (int i = 0; i < 5; i++)
        begin
            {fly_oc, drv_uv, drv_ov, core_uv, core_ov} = 5'h01 << i;
            cyc(6);
            {fly_oc, drv_uv, drv_ov, core_uv, core_ov} = 5'h00;
            chk("full_stop", {6'h0, fly_run, main_run}, 8'h00);
            wt(0);
            chk("hiccup", 8'(n), 8'(HC - 3));
            wt(2);
            rchk("fly_stat", 8'hD3, 8'h01 << i);
            clr();
        end
        $display("t_rails done");
    endtask
    task t_avg_latch();
        wreg(8'hB0, 8'h80);
        wreg(8'hB4, 8'h10);
        avg_oc = 1;
        cyc(6);
        avg_oc = 0;
        cyc(3 * HC);
        chk("part_latch", {6'h0, fly_run, main_run}, 8'h02);
        rchk("oc_stat", 8'hD5, 8'h20);
        go_sw = 1;
        cyc(3);
        go_sw = 0;
        wt(1);
        wt(2);
        clr();
        wreg(8'hB0, 8'h00);
        wreg(8'hB4, 8'h00);
        $display("t_avg_latch done");
    endtask
    // input overvoltage forces init, where the latch-off strap is taken
    task t_pin_latch();
        m_lat = 1;
        in_ov = 1;
        cyc(2 * HC);
        chk("in_ov", {6'h0, fly_run, main_run}, 8'h00);
        in_ov = 0;
        wt(2);
        chk("fpwm", {7'h0, fpwm}, 8'h01);
        core_uv = 1;
        cyc(6);
        core_uv = 0;
        cyc(3 * HC);
        chk("latched", {6'h0, fly_run, main_run}, 8'h00);
        go_en = 1;
        cyc(3);
        go_en = 0;
        wt(0);
        wt(2);
        rchk("fly_stat", 8'hD3, 8'h02);
        $display("t_pin_latch done");
    endtask
    initial
    begin
        cyc(6);
        rst = 0;
        wt(2);
        t_regs();
        t_limits();
        t_rails();
        t_avg_latch();
        t_pin_latch();
        stop_test();
    end
endmodule
bind cfm_fault_manager cfm_fm_properties #(.NPH(NPH)) chk_i (.CLK_SYS, .RST, .INPUT_SUPPLY_OV,
    .BOOST_MODE, .REG_WR, .PEAK_CURRENT_LIMIT, .NEGATIVE_CURRENT_LIMIT, .HS_GATE, .LS_GATE,
    .ALERT_FLAG_N, .MAIN_RUN, .FLYBACK_RUN, .SOFTSTART_REQ, .FORCED_PWM);
`default_nettype wire
